/* File: dio_port.sv */
// twelve-line digital port with edge counter and aux power switch
// How it works
// - twelve lines form one port: eight-line group plus four-line group.
// - every line has its own direction bit.
// - default drive is open collector: pull low, else release.
// - a per-line push-pull option drives both levels actively.
// - reset leaves all lines as undriven inputs.
// - sampling and output updates happen only on software strobes.
// - selected edge-count input increments a 32-bit counter on falls.
// - aux power output is off while the bus is suspended.
`timescale 1ns/1ps
`default_nettype none
module dio_port #(
	parameter bit PUSH_PULL_AVAILABLE = 1'b1
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic [dio_pkg::WIDE_LINES-1:0] I_WIDE_GROUP_LINES,
	input wire logic [dio_pkg::NARROW_LINES-1:0] I_NARROW_GROUP_LINES,
	output logic [dio_pkg::WIDE_LINES-1:0] O_WIDE_GROUP_LINES,
	output logic [dio_pkg::WIDE_LINES-1:0] O_WIDE_GROUP_LINES_OE,
	output logic [dio_pkg::NARROW_LINES-1:0] O_NARROW_GROUP_LINES,
	output logic [dio_pkg::NARROW_LINES-1:0] O_NARROW_GROUP_LINES_OE,
	input wire logic [dio_pkg::PORT_LINES-1:0] I_DIR,
	input wire logic [dio_pkg::PORT_LINES-1:0] I_PUSH_PULL,
	input wire logic I_CONFIG_WRITE,
	input wire logic [dio_pkg::PORT_LINES-1:0] I_OUT_LEVEL,
	input wire logic I_UPDATE,
	input wire logic I_SAMPLE,
	output logic [dio_pkg::PORT_LINES-1:0] O_SAMPLED,
	output logic O_SAMPLE_DONE,
	input wire logic I_EDGE_COUNT_INPUT,
	input wire logic I_COUNT_ENABLE,
	input wire logic I_COUNT_CLEAR,
	output logic [dio_pkg::COUNT_WIDTH-1:0] O_COUNT,
	input wire logic I_SUSPEND,
	output logic O_AUX_POWER_EN
);
	localparam int N = dio_pkg::PORT_LINES;
	localparam int W = dio_pkg::WIDE_LINES;

	logic [N-1:0] dir;
	logic [N-1:0] push_pull;
	logic [N-1:0] level;
	logic [N-1:0] pin_meta;
	logic [N-1:0] pin_sync;
	logic cnt_meta;
	logic cnt_sync;
	logic susp_meta;
	logic susp_sync;
	// nets: each line's generate branch drives only its own bit
	wire logic [N-1:0] next_level;
	wire logic [N-1:0] next_oe;
	dio_pkg::pin_drive_t next_drive;

	initial begin
		if (N != 12) begin
			$error("port must hold twelve lines");
		end
		if (N != W + dio_pkg::NARROW_LINES) begin
			$error("line groups must add up to the port");
		end
		if ($bits(dio_pkg::pin_drive_t) != 2 * N) begin
			$error("drive bundle needs a level and an enable per line");
		end
		if (dio_pkg::COUNT_WIDTH != 32) begin
			$error("event counter must be 32 bits wide");
		end
		if (dio_pkg::DIR_RESET != '0) begin
			$error("every line must come out of reset as an input");
		end
		if (dio_pkg::PUSH_PULL_RESET != '0) begin
			$error("every line must come out of reset open collector");
		end
		if (dio_pkg::LEVEL_RESET != '1) begin
			$error("reset level must leave open collector lines released");
		end
	end

	// pins come from outside: two flops before anything reads them
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {I_NARROW_GROUP_LINES, I_WIDE_GROUP_LINES};
			pin_sync <= pin_meta;
		end
	end

	// idles high on its pull-up; a low reset would fake a fall
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			cnt_meta <= 1'b1;
			cnt_sync <= 1'b1;
		end else begin
			cnt_meta <= I_EDGE_COUNT_INPUT;
			cnt_sync <= cnt_meta;
		end
	end

	// suspend comes from the bus side, another timing domain
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			susp_meta <= 1'b0;
			susp_sync <= 1'b0;
		end else begin
			susp_meta <= I_SUSPEND;
			susp_sync <= susp_meta;
		end
	end

	// direction held until software writes it again
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			dir <= dio_pkg::DIR_RESET;
		end else if (I_CONFIG_WRITE) begin
			dir <= I_DIR;
		end
	end

	// drive type loads with the same strobe as direction
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			push_pull <= dio_pkg::PUSH_PULL_RESET;
		end else if (I_CONFIG_WRITE) begin
			// without the option the lines stay open collector
			push_pull <= PUSH_PULL_AVAILABLE ? I_PUSH_PULL : '0;
		end
	end

	// output levels change only on an update strobe
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			level <= dio_pkg::LEVEL_RESET;
		end else if (I_UPDATE) begin
			level <= I_OUT_LEVEL;
		end
	end

	// inputs captured only on a sample strobe
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_SAMPLED <= '0;
		end else if (I_SAMPLE) begin
			O_SAMPLED <= pin_sync;
		end
	end

	// one-cycle acknowledge of each sample strobe
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_SAMPLE_DONE <= 1'b0;
		end else begin
			O_SAMPLE_DONE <= I_SAMPLE;
		end
	end

	// per-line drive decision
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_line
			// only a push-pull line ever drives a high level
			assign next_level[g] = push_pull[g] & level[g];
			// an input line is never driven, whatever its level;
			// open collector drives only to pull the line low
			assign next_oe[g] = dir[g]
				& (push_pull[g] | ~level[g]);
		end
	endgenerate

	// bundle both halves of the drive decision
	always_comb begin
		next_drive.level = next_level;
		next_drive.oe = next_oe;
	end

	// wide group pins, registered straight to the outputs
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_WIDE_GROUP_LINES <= '0;
			O_WIDE_GROUP_LINES_OE <= '0;
		end else begin
			O_WIDE_GROUP_LINES <= next_drive.level[W-1:0];
			O_WIDE_GROUP_LINES_OE <= next_drive.oe[W-1:0];
		end
	end

	// narrow group pins, same timing as the wide group
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_NARROW_GROUP_LINES <= '0;
			O_NARROW_GROUP_LINES_OE <= '0;
		end else begin
			O_NARROW_GROUP_LINES <= next_drive.level[N-1:W];
			O_NARROW_GROUP_LINES_OE <= next_drive.oe[N-1:W];
		end
	end

	edge_counter #(
		.WIDTH(dio_pkg::COUNT_WIDTH)
	) u_counter (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_enable(I_COUNT_ENABLE),
		.i_clear(I_COUNT_CLEAR),
		.i_level(cnt_sync),
		.o_count(O_COUNT)
	);

	// power is off during reset and comes on the first clock after it, as the suspend synchroniser resets to not suspended
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_AUX_POWER_EN <= 1'b0;
		end else begin
			O_AUX_POWER_EN <= ~susp_sync;
		end
	end
endmodule
`default_nettype wire

/* File: dio_pkg.sv */
// shared constants and carrier types for the digital port block
package dio_pkg;
	localparam int WIDE_LINES = 8;
	localparam int NARROW_LINES = 4;
	localparam int PORT_LINES = WIDE_LINES + NARROW_LINES;
	localparam int COUNT_WIDTH = 32;
	localparam logic [PORT_LINES-1:0] DIR_RESET = 12'h000;
	localparam logic [PORT_LINES-1:0] LEVEL_RESET = 12'hfff;
	localparam logic [PORT_LINES-1:0] PUSH_PULL_RESET = 12'h000;
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [COUNT_WIDTH-1:0] COUNT_STEP = 32'h0000_0001;

	// per-line pin drive bundle
	typedef struct packed {
		logic [PORT_LINES-1:0] level;
		logic [PORT_LINES-1:0] oe;
	} pin_drive_t;
endpackage

/* File: edge_counter.sv */
// falling-edge event counter on an already synchronised input
`timescale 1ns/1ps
`default_nettype none
module edge_counter #(
	parameter int WIDTH = 32
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic i_clear,
	input wire logic i_level,
	output logic [WIDTH-1:0] o_count
);
	logic last_level;

	initial begin
		if (WIDTH < 1) begin
			$error("edge_counter width must be positive");
		end
	end

	// idle level is high because of the pull-up
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			last_level <= 1'b1;
		end else begin
			last_level <= i_level;
		end
	end

	// wraps from all ones to zero by natural overflow
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_clear) begin
			o_count <= '0;
		end else if (i_enable && last_level && !i_level) begin
			o_count <= o_count + WIDTH'(1);
		end
	end
endmodule
`default_nettype wire

/* File: dio_pins.sv */
// pin model: port drive and outside drivers
`timescale 1ns/1ps
`default_nettype none
module dio_pins (
	input wire logic [11:0] i_val,
	input wire logic [11:0] i_oe,
	input wire logic [11:0] i_ext,
	output logic [11:0] o_wire
);
	// a line the port does not drive reads the outside value i_ext
	assign o_wire = (i_oe & i_val) | (~i_oe & i_ext);
endmodule
`default_nettype wire

/* File: dio_port_chk.sv */
// port output checks
`timescale 1ns/1ps
`default_nettype none
module dio_port_chk (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_CONFIG_WRITE,
	input wire logic I_UPDATE,
	input wire logic I_SAMPLE,
	input wire logic I_SUSPEND,
	input wire logic [7:0] O_WIDE_GROUP_LINES_OE,
	input wire logic [11:0] O_SAMPLED,
	input wire logic O_SAMPLE_DONE,
	input wire logic [31:0] O_COUNT,
	input wire logic O_AUX_POWER_EN
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_up; !I_SUSPEND [*5]; endsequence
	sequence s_down; I_SUSPEND [*5]; endsequence
	a_reset_idle: assert property ($rose(I_RST_N) |->
		O_WIDE_GROUP_LINES_OE == 8'h00) else $error("oe on");
	a_done_after: assert property (I_SAMPLE |=> O_SAMPLE_DONE)
		else $error("no done");
	a_done_cause: assert property (O_SAMPLE_DONE |-> $past(I_SAMPLE))
		else $error("stray done");
	a_sample_held: assert property ($changed(O_SAMPLED) |->
		$past(I_SAMPLE)) else $error("sample moved");
	a_oe_strobe: assert property ($changed(O_WIDE_GROUP_LINES_OE) |->
		$past(I_CONFIG_WRITE, 2) || $past(I_UPDATE, 2)) else $error("oe moved");
	a_count_step: assert property ($changed(O_COUNT) |->
		O_COUNT == $past(O_COUNT) + 32'h1 || O_COUNT == 32'h0)
		else $error("count jump");
	a_aux_on: assert property (s_up |-> O_AUX_POWER_EN)
		else $error("aux off");
	a_aux_off: assert property (s_down |-> !O_AUX_POWER_EN)
		else $error("aux on");
endmodule
bind dio_port dio_port_chk u_chk (.I_CORE_CLK, .I_RST_N, .I_CONFIG_WRITE,
	.I_UPDATE, .I_SAMPLE, .I_SUSPEND, .O_WIDE_GROUP_LINES_OE, .O_SAMPLED,
	.O_SAMPLE_DONE, .O_COUNT, .O_AUX_POWER_EN);
`default_nettype wire

/* File: dio_port_tb.sv */
// bench for the digital port
`timescale 1ns/1ps
`default_nettype none
module dio_port_tb;
	logic I_CORE_CLK = 0, I_RST_N = 0, I_CONFIG_WRITE = 0, I_UPDATE = 0;
	logic I_SAMPLE = 0, I_EDGE_COUNT_INPUT = 1, I_COUNT_ENABLE = 0;
	logic I_COUNT_CLEAR = 0, I_SUSPEND = 0;
	logic [11:0] I_DIR = 0, I_PUSH_PULL = 0, I_OUT_LEVEL = 0, ext = 0, e;
	wire [11:0] val, oe, pins, O_SAMPLED;
	wire [31:0] O_COUNT;
	wire O_SAMPLE_DONE, O_AUX_POWER_EN;
	int err_count = 0, tests_run = 0;
	dio_port u_dio_port (.I_CORE_CLK, .I_RST_N,
		.I_WIDE_GROUP_LINES(pins[7:0]), .I_NARROW_GROUP_LINES(pins[11:8]),
		.O_WIDE_GROUP_LINES(val[7:0]), .O_WIDE_GROUP_LINES_OE(oe[7:0]),
		.O_NARROW_GROUP_LINES(val[11:8]), .O_NARROW_GROUP_LINES_OE(oe[11:8]),
		.I_DIR, .I_PUSH_PULL, .I_CONFIG_WRITE, .I_OUT_LEVEL, .I_UPDATE,
		.I_SAMPLE, .O_SAMPLED, .O_SAMPLE_DONE, .I_EDGE_COUNT_INPUT,
		.I_COUNT_ENABLE, .I_COUNT_CLEAR, .O_COUNT, .I_SUSPEND, .O_AUX_POWER_EN);
	dio_pins u_dio_pins (.i_val(val), .i_oe(oe), .i_ext(ext), .o_wire(pins));
	always #10 I_CORE_CLK = ~I_CORE_CLK;
	task automatic cyc(int n);
		repeat (n) @(negedge I_CORE_CLK);
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			err_count++;
			$display("Error %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic rst;
		I_RST_N = 0;
		ext = 12'hfff;
		cyc(20);
		I_RST_N = 1;
		cyc(1);
		chk("oe", 0, oe);
		chk("pins", 12'hfff, pins);
		$display("reset test done");
	endtask
	initial begin
		void'($urandom(32'h0d45));
		rst();
		for (int t = 0; t < 40; t++) begin
			I_DIR = (t == 0) ? 12'hfff : 12'($urandom);
			I_PUSH_PULL = (t == 1) ? 12'hfff : 12'($urandom);
			I_OUT_LEVEL = 12'($urandom);
			// outside drivers stay off output lines
			ext = 12'($urandom) | I_DIR;
			I_CONFIG_WRITE = 1;
			I_UPDATE = 1;
			cyc(1);
			I_CONFIG_WRITE = 0;
			I_UPDATE = 0;
			cyc(3);
			chk("oe", I_DIR & (I_PUSH_PULL | ~I_OUT_LEVEL), oe);
			e = (I_DIR & I_OUT_LEVEL) | (~I_DIR & ext);
			I_SAMPLE = 1;
			cyc(1);
			I_SAMPLE = 0;
			cyc(1);
			chk("sampled", e, O_SAMPLED);
		end
		$display("line test done");
		I_COUNT_CLEAR = 1;
		I_COUNT_ENABLE = 1;
		cyc(3);
		I_COUNT_CLEAR = 0;
		e = 12'($urandom_range(20, 5));
		repeat (e) begin
			I_EDGE_COUNT_INPUT = 0;
			cyc(2);
			I_EDGE_COUNT_INPUT = 1;
			cyc(2);
		end
		cyc(4);
		chk("count", e, O_COUNT);
		// a fall while counting is off must leave the count alone
		I_COUNT_ENABLE = 0;
		I_EDGE_COUNT_INPUT = 0;
		cyc(2);
		I_EDGE_COUNT_INPUT = 1;
		cyc(4);
		chk("count off", e, O_COUNT);
		$display("count test done");
		rst();
		I_SUSPEND = 1;
		cyc(5);
		chk("aux", 0, O_AUX_POWER_EN);
		I_SUSPEND = 0;
		cyc(5);
		chk("aux", 1, O_AUX_POWER_EN);
		$display("aux test done");
		end_sim();
	end
	// tests need well under 600 cycles
	initial begin
		repeat (2000) @(posedge I_CORE_CLK);
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
